// file: hw/pcix_host_bus_pkg.sv
// Constants for the host bus interface block
// Behaviour
// (R01) PCI-X: assert frame within 6 clocks of grant
// (R02) PCI: assert frame within 16 clocks of grant
// (R03) Odd-DWORD 64-bit register access moves upper data correctly
// (R04) Filter table writes work at any alignment
// (R05) Segmentation fetches split at 8 Kbytes
// (R06) Host splits jumbo frames over several buffers
// (R07) Flash window refuses 64-bit width
// (R08) Zero-byte flash write causes no flash access
// (R09) Flash disable from init word; ROM BAR zero
// (R10) ROM size follows setting; disabled never claims
// (R11) Host keeps flash disable bit cleared
// (R12) Alignment and DMA limits only in PCI-X; code also splits TSO fetches and handles odd-DWORD lanes in PCI mode
// (R13) Sample REQ64 at reset release for width
// (R14) Bus mode fixed until next reset
// (R15) 32-bit register write touches one DWORD only
package pcix_host_bus_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int GNT_FRAME_PCIX_CLK = 6;
  localparam int GNT_FRAME_PCI_CLK  = 16;
  localparam logic [4:0] GNT_WAIT_LIMIT_PCIX = 5'h06;
  localparam logic [4:0] GNT_WAIT_LIMIT_PCI  = 5'h10;

  // ************************************************************
  // DMA
  // ************************************************************
  localparam logic [15:0] DMA_MAX_BYTES = 16'h2000;

  // ************************************************************
  // Initialisation word and expansion ROM
  // ************************************************************
  localparam logic [7:0]  INIT_WORD2_ADDR  = 8'h0f;
  localparam int          FLASH_DIS_BIT    = 8;
  localparam logic [31:0] ROM_MIN_SIZE     = 32'h0001_0000;
  localparam int          ROM_BAR_EN_BIT   = 0;
  localparam logic [31:0] ROM_BAR_RESET    = 32'h0000_0000;

  // ************************************************************
  // Initiator states
  // ************************************************************
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_REQ  = 4'b0010,
    M_DATA = 4'b0100,
    M_TURN = 4'b1000
  } mst_state_type;

endpackage

// file: hw/pcix_host_bus_interface.sv
// Host bus target and initiator logic of the network controller
`timescale 1ns/10ps
module pcix_host_bus_interface #(
  parameter int REG_WORDS = 64,
  parameter int IDX_W     = 6
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        req64_n_pin,
  input  wire logic        pcix_mode_pin,
  input  wire logic        gnt_n_pin,
  input  wire logic        bus_idle_pin,
  output logic             bus_req_n,
  output logic             frame_n_out,
  output logic             frame_oe_n,
  output logic [31:0]      mst_addr,
  output logic [15:0]      mst_len,
  input  wire logic        eeprom_word_valid,
  input  wire logic [7:0]  eeprom_word_addr,
  input  wire logic [15:0] eeprom_word_data,
  input  wire logic [1:0]  flash_size,
  input  wire logic        rom_bar_we,
  input  wire logic [31:0] rom_bar_wdata,
  output logic [31:0]      rom_bar_rdata,
  input  wire logic        tgt_valid,
  input  wire logic        tgt_reg_sel,
  input  wire logic        tgt_write,
  input  wire logic        tgt_req64,
  input  wire logic [31:0] tgt_addr,
  input  wire logic [63:0] tgt_wdata,
  input  wire logic [7:0]  tgt_be_n,
  output logic             tgt_claim,
  output logic             tgt_done,
  output logic             tgt_ack64_n,
  output logic [63:0]      tgt_rdata,
  output logic             flash_cs_n,
  output logic             flash_we_n,
  output logic [18:0]      flash_addr,
  output logic [31:0]      flash_wdata,
  input  wire logic [31:0] flash_rdata,
  input  wire logic        dma_req_valid,
  input  wire logic        dma_req_tso,
  input  wire logic [31:0] dma_req_addr,
  input  wire logic [15:0] dma_req_len,
  output logic             dma_req_ready,
  output logic             dma_busy
);

  initial begin
    if (REG_WORDS != (1 << IDX_W) || IDX_W < 2) begin
      $error("REG_WORDS must equal 2**IDX_W");
    end
  end

  // Byte-enable merge, used on both register lanes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be_n);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (!be_n[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] req64_sync_reg;
  logic [1:0] mode_sync_reg;
  logic [1:0] gnt_sync_reg;
  logic [1:0] idle_sync_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req64_sync_reg <= 2'h3;
      mode_sync_reg  <= 2'h0;
      gnt_sync_reg   <= 2'h3;
      idle_sync_reg  <= 2'h0;
    end else begin
      req64_sync_reg <= {req64_sync_reg[0], req64_n_pin};
      mode_sync_reg  <= {mode_sync_reg[0], pcix_mode_pin};
      gnt_sync_reg   <= {gnt_sync_reg[0], gnt_n_pin};
      idle_sync_reg  <= {idle_sync_reg[0], bus_idle_pin};
    end
  end

  wire gnt_seen = !gnt_sync_reg[1];
  wire bus_idle = idle_sync_reg[1];

  // ************************************************************
  // Strap capture at reset release
  // ************************************************************
  // Straps pass the synchroniser first, so they are taken on the
  // third edge after release; the host holds them stable meanwhile.
  logic [1:0] init_cnt_reg;
  logic       init_done_reg;
  logic       bus64_reg;
  logic       pcix_mode_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_cnt_reg  <= 2'h0;
      init_done_reg <= 1'b0;
      bus64_reg     <= 1'b0;
      pcix_mode_reg <= 1'b0;
    end else if (!init_done_reg) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
      if (init_cnt_reg == 2'h2) begin
        init_done_reg <= 1'b1;
        bus64_reg     <= !req64_sync_reg[1]; // R13
        pcix_mode_reg <= mode_sync_reg[1]; // R14
      end
    end
  end

  // ************************************************************
  // Initialisation word and expansion ROM decode
  // ************************************************************
  logic        flash_dis_reg;
  logic [31:0] rom_base_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_dis_reg <= 1'b0;
      rom_base_reg  <= pcix_host_bus_pkg::ROM_BAR_RESET;
    end else begin
      if (eeprom_word_valid &&
          eeprom_word_addr == pcix_host_bus_pkg::INIT_WORD2_ADDR) begin
        flash_dis_reg <=
          eeprom_word_data[pcix_host_bus_pkg::FLASH_DIS_BIT]; // R09
      end
      if (rom_bar_we) begin
        rom_base_reg <= rom_bar_wdata;
      end
    end
  end

  wire [31:0] rom_size = pcix_host_bus_pkg::ROM_MIN_SIZE << flash_size;
  wire [31:0] rom_mask = ~(rom_size - 32'h1);
  // Disabled flash never decodes, not even at base zero
  wire rom_hit = !flash_dis_reg &&
                 rom_base_reg[pcix_host_bus_pkg::ROM_BAR_EN_BIT] &&
                 ((tgt_addr & rom_mask) ==
                  (rom_base_reg & rom_mask)); // R10
  assign rom_bar_rdata = flash_dis_reg ? 32'h0000_0000
                                       : (rom_base_reg & rom_mask); // R09

  // ************************************************************
  // Register target
  // ************************************************************
  // The filter tables and flow-control address words live in this array
  logic [31:0] reg_mem [REG_WORDS];

  wire [IDX_W-1:0] idx      = tgt_addr[IDX_W+1:2];
  wire [IDX_W-1:0] idx_next = idx + {{(IDX_W-1){1'b0}}, 1'b1};
  wire [IDX_W-1:0] idx_even = {idx[IDX_W-1:1], 1'b0};
  wire             odd_dw   = tgt_addr[2];
  wire reg_acc  = tgt_valid && tgt_reg_sel;
  wire ack64    = reg_acc && tgt_req64 && bus64_reg;
  wire reg_wr   = reg_acc && tgt_write;
  // Odd start: first datum rides the upper lane into the addressed word
  // A 32-bit access uses the lower lane at either alignment
  wire wr_lo    = reg_wr && !(odd_dw && ack64); // R04 R15
  wire wr_hi    = reg_wr && ack64; // R03 R04 R12
  wire [IDX_W-1:0] hi_idx = odd_dw ? idx : idx_next; // R03
  wire [IDX_W-1:0] rd_lo_idx = ack64 ? idx_even : idx; // R15

  always_ff @(posedge clk) begin
    if (wr_lo) begin
      reg_mem[idx] <= be_merge(reg_mem[idx], tgt_wdata[31:0],
                               tgt_be_n[3:0]); // R15
    end
    if (wr_hi) begin
      reg_mem[hi_idx] <= be_merge(reg_mem[hi_idx], tgt_wdata[63:32],
                                  tgt_be_n[7:4]); // R03 R04
    end
  end

  // ************************************************************
  // Flash window
  // ************************************************************
  wire flash_acc = tgt_valid && !tgt_reg_sel && rom_hit;
  // 32-bit data sits on the lower lane; width is always refused
  wire flash_wr  = flash_acc && tgt_write &&
                   (tgt_be_n[3:0] != 4'hf); // R07 R08
  wire flash_rd  = flash_acc && !tgt_write;
  logic flash_rd_pend_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cs_n        <= 1'b1;
      flash_we_n        <= 1'b1;
      flash_addr        <= 19'h00000;
      flash_wdata       <= 32'h0000_0000;
      flash_rd_pend_reg <= 1'b0;
    end else begin
      flash_cs_n        <= !(flash_wr || flash_rd); // R08
      flash_we_n        <= !flash_wr; // R08
      flash_rd_pend_reg <= flash_rd;
      if (flash_wr || flash_rd) begin
        flash_addr  <= tgt_addr[18:0] & ~rom_mask[18:0];
        flash_wdata <= tgt_wdata[31:0];
      end
    end
  end

  // ************************************************************
  // Target answer
  // ************************************************************
  // Zero-byte flash writes still complete on the bus, silently
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgt_claim   <= 1'b0;
      tgt_done    <= 1'b0;
      tgt_ack64_n <= 1'b1;
      tgt_rdata   <= 64'h0;
    end else begin
      tgt_claim   <= reg_acc || flash_acc; // R10
      tgt_done    <= reg_acc || (flash_acc && tgt_write) ||
                     flash_rd_pend_reg;
      tgt_ack64_n <= !ack64; // R07
      if (reg_acc && !tgt_write) begin
        tgt_rdata <= {reg_mem[idx_even + {{(IDX_W-1){1'b0}}, 1'b1}],
                      reg_mem[rd_lo_idx]};
      end else if (flash_rd_pend_reg) begin
        tgt_rdata <= {32'h0000_0000, flash_rdata};
      end
    end
  end

  // ************************************************************
  // Initiator: transmit DMA
  // ************************************************************
  pcix_host_bus_pkg::mst_state_type st_reg;
  pcix_host_bus_pkg::mst_state_type st_next;
  logic [15:0] rem_reg;
  logic [31:0] cur_addr_reg;
  logic        split_reg;
  logic [15:0] beat_reg;
  logic [4:0]  gnt_wait_reg;

  // Large requests break the bus in PCI-X and for TSO; other PCI requests keep the whole length
  wire        split_need = dma_req_tso || pcix_mode_reg; // R05 R12
  wire        chunk_cut  = split_reg &&
                           (rem_reg > pcix_host_bus_pkg::DMA_MAX_BYTES);
  wire [15:0] chunk_len  = chunk_cut ? pcix_host_bus_pkg::DMA_MAX_BYTES
                                     : rem_reg; // R05
  // One spare bit so long unsplit lengths do not wrap when rounded up
  wire [16:0] beats_x    = bus64_reg ? (({1'b0, chunk_len} + 17'h7) >> 3)
                                     : (({1'b0, chunk_len} + 17'h3) >> 2);
  wire [15:0] beats      = beats_x[15:0];
  wire        start_ok   = gnt_seen && bus_idle;

  assign dma_req_ready = init_done_reg && (st_reg == pcix_host_bus_pkg::M_IDLE)
                         && (rem_reg == 16'h0);
  assign dma_busy      = (rem_reg != 16'h0);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      pcix_host_bus_pkg::M_IDLE: begin
        if (rem_reg != 16'h0) st_next = pcix_host_bus_pkg::M_REQ;
      end
      pcix_host_bus_pkg::M_REQ: begin
        if (start_ok) st_next = pcix_host_bus_pkg::M_DATA; // R01 R02
      end
      pcix_host_bus_pkg::M_DATA: begin
        if (beat_reg == 16'h1) st_next = pcix_host_bus_pkg::M_TURN;
      end
      pcix_host_bus_pkg::M_TURN: begin
        st_next = pcix_host_bus_pkg::M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= pcix_host_bus_pkg::M_IDLE;
      rem_reg      <= 16'h0;
      cur_addr_reg <= 32'h0;
      split_reg    <= 1'b0;
      beat_reg     <= 16'h0;
      gnt_wait_reg <= 5'h0;
      bus_req_n    <= 1'b1;
      frame_n_out  <= 1'b1;
      frame_oe_n   <= 1'b1;
      mst_addr     <= 32'h0;
      mst_len      <= 16'h0;
    end else begin
      st_reg <= st_next;
      if (dma_req_valid && dma_req_ready) begin
        rem_reg      <= dma_req_len;
        cur_addr_reg <= dma_req_addr;
        split_reg    <= split_need;
      end
      bus_req_n <= !(st_next == pcix_host_bus_pkg::M_REQ);
      gnt_wait_reg <= (st_reg == pcix_host_bus_pkg::M_REQ && gnt_seen)
                      ? gnt_wait_reg + 5'h1 : 5'h0;
      if (st_reg == pcix_host_bus_pkg::M_REQ && start_ok) begin
        // Frame drops in the very cycle the grant is honoured
        frame_n_out  <= 1'b0; // R01 R02
        frame_oe_n   <= 1'b0;
        mst_addr     <= cur_addr_reg;
        mst_len      <= chunk_len;
        beat_reg     <= (beats == 16'h0) ? 16'h1 : beats;
        rem_reg      <= rem_reg - chunk_len;
        cur_addr_reg <= cur_addr_reg + {16'h0, chunk_len};
      end else if (st_reg == pcix_host_bus_pkg::M_DATA) begin
        beat_reg <= beat_reg - 16'h1;
        if (beat_reg == 16'h1) frame_n_out <= 1'b1;
      end else if (st_reg == pcix_host_bus_pkg::M_TURN) begin
        frame_oe_n <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  localparam int GNT_LIM_X = pcix_host_bus_pkg::GNT_FRAME_PCIX_CLK;
  localparam int GNT_LIM_P = pcix_host_bus_pkg::GNT_FRAME_PCI_CLK;

  a_pcix_gnt_frame: assert property ( // R01
    @(posedge clk) disable iff (sys_rst)
    (pcix_mode_reg && st_reg == pcix_host_bus_pkg::M_REQ)
      |-> gnt_wait_reg < GNT_LIM_X)
    else $error("PCI-X frame late after grant");

  a_pci_gnt_frame: assert property ( // R02
    @(posedge clk) disable iff (sys_rst)
    (!pcix_mode_reg && st_reg == pcix_host_bus_pkg::M_REQ)
      |-> gnt_wait_reg < GNT_LIM_P)
    else $error("PCI frame late after grant");

  a_odd_dword_hi: assert property ( // R03
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && ack64 && odd_dw && tgt_be_n == 8'h00)
      |=> reg_mem[$past(idx)] == $past(tgt_wdata[63:32]))
    else $error("Upper DWORD lost at odd offset");

  a_dword_only: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && !ack64)
      |=> reg_mem[$past(idx_next)] == $past(reg_mem[idx_next]))
    else $error("32-bit write disturbed neighbour");

  a_dma_chunk_max: assert property ( // R05
    @(posedge clk) disable iff (sys_rst)
    (split_reg && st_reg == pcix_host_bus_pkg::M_DATA)
      |-> mst_len <= pcix_host_bus_pkg::DMA_MAX_BYTES)
    else $error("DMA request above limit");

  a_flash_no64: assert property ( // R07
    @(posedge clk) disable iff (sys_rst)
    flash_acc |=> tgt_ack64_n && tgt_claim)
    else $error("Flash window took 64-bit width");

  a_flash_zero_be: assert property ( // R08
    @(posedge clk) disable iff (sys_rst)
    (flash_acc && tgt_write && tgt_be_n[3:0] == 4'hf)
      |=> flash_cs_n && flash_we_n)
    else $error("Zero-byte write reached flash");

  a_rom_bar_zero: assert property ( // R09
    @(posedge clk) disable iff (sys_rst)
    flash_dis_reg |-> rom_bar_rdata == 32'h0000_0000)
    else $error("ROM BAR not zero when disabled");

  a_rom_no_claim: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    (flash_dis_reg && tgt_valid && !tgt_reg_sel) |=> !tgt_claim)
    else $error("Disabled ROM claimed a cycle");

  a_mode_fixed: assert property ( // R13 R14
    @(posedge clk) disable iff (sys_rst)
    (init_done_reg && $past(init_done_reg))
      |-> $stable(pcix_mode_reg) && $stable(bus64_reg))
    else $error("Bus mode changed after reset");

endmodule

// file: verif/bus_arbiter_model.sv
// Arbiter and strap model standing on the far side of the host bus
`timescale 1ns/10ps
module bus_arbiter_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       strap_pcix,
  input  wire logic       strap_wide,
  input  wire logic [3:0] grant_delay,
  input  wire logic       bus_req_n,
  input  wire logic       frame_oe_n,
  output logic            gnt_n_pin,
  output logic            bus_idle_pin,
  output logic            req64_n_pin,
  output logic            pcix_mode_pin
);
  logic [3:0] wait_reg;

  // ****
  // Straps and idle
  // ****
  // Bench moves straps inside reset and sets strap_pcix once after capture; both are stable at release
  assign req64_n_pin   = ~strap_wide;
  assign pcix_mode_pin = strap_pcix;
  // Sole initiator on the segment: idle means frame not driven
  assign bus_idle_pin  = frame_oe_n;

  // ****
  // Grant
  // ****
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg  <= 4'h0;
      gnt_n_pin <= 1'b1;
    end else if (bus_req_n || !frame_oe_n) begin
      wait_reg  <= 4'h0;
      gnt_n_pin <= 1'b1;
    end else if (wait_reg < grant_delay) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      gnt_n_pin <= 1'b0;
    end
  end
endmodule

// file: verif/tb.sv
// Self-checking bench for the host bus interface block
`timescale 1ns/10ps
module tb;
  logic        clk, sys_rst, strap_pcix, strap_wide, pcix_now, oe_was;
  logic [3:0]  grant_delay;
  logic        req64_n_pin, pcix_mode_pin, gnt_n_pin, bus_idle_pin;
  logic        bus_req_n, frame_n_out, frame_oe_n;
  logic [31:0] mst_addr, rom_bar_wdata, rom_bar_rdata, tgt_addr;
  logic [15:0] mst_len, eeprom_word_data, dma_req_len;
  logic        eeprom_word_valid, rom_bar_we, tgt_valid, tgt_reg_sel;
  logic [7:0]  eeprom_word_addr, tgt_be_n;
  logic [1:0]  flash_size;
  logic        tgt_write, tgt_req64, tgt_claim, tgt_done, tgt_ack64_n;
  logic [63:0] tgt_wdata, tgt_rdata, seen_rdata;
  logic        flash_cs_n, flash_we_n, dma_req_valid, dma_req_tso;
  logic [18:0] flash_addr;
  logic [31:0] flash_wdata, flash_rdata, dma_req_addr, last_wdata;
  logic        dma_req_ready, dma_busy, seen_claim, seen_done, seen_ack;
  int          mismatches, n_checks, gcnt, n_we, n_cs;

  pcix_host_bus_interface u_pcix_host_bus_interface (
    .clk, .sys_rst, .req64_n_pin, .pcix_mode_pin, .gnt_n_pin,
    .bus_idle_pin, .bus_req_n, .frame_n_out, .frame_oe_n, .mst_addr,
    .mst_len, .eeprom_word_valid, .eeprom_word_addr, .eeprom_word_data,
    .flash_size, .rom_bar_we, .rom_bar_wdata, .rom_bar_rdata, .tgt_valid,
    .tgt_reg_sel, .tgt_write, .tgt_req64, .tgt_addr, .tgt_wdata,
    .tgt_be_n, .tgt_claim, .tgt_done, .tgt_ack64_n, .tgt_rdata,
    .flash_cs_n, .flash_we_n, .flash_addr, .flash_wdata, .flash_rdata,
    .dma_req_valid, .dma_req_tso, .dma_req_addr, .dma_req_len,
    .dma_req_ready, .dma_busy);

  bus_arbiter_model u_bus_arbiter_model (
    .clk, .sys_rst, .strap_pcix, .strap_wide, .grant_delay, .bus_req_n,
    .frame_oe_n, .gnt_n_pin, .bus_idle_pin, .req64_n_pin, .pcix_mode_pin);

  // ****
  // Common tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic pcix, input logic wide);
    @(negedge clk);
    sys_rst = 1'b1;
    strap_pcix = pcix;
    strap_wide = wide;
    pcix_now = pcix;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    // Straps must stay put until the design has captured them
    repeat (6) @(negedge clk);
  endtask

  task automatic tgt_op(input logic sel, input logic wr, input logic r64,
                        input logic [31:0] a, input logic [63:0] d,
                        input logic [7:0] be);
    @(negedge clk);
    tgt_valid = 1'b1;
    tgt_reg_sel = sel;
    tgt_write = wr;
    tgt_req64 = r64;
    tgt_addr = a;
    tgt_wdata = d;
    tgt_be_n = be;
    @(negedge clk);
    tgt_valid = 1'b0;
    seen_claim = 1'b0;
    seen_done = 1'b0;
    seen_ack = 1'b1;
    // Flash reads answer a cycle later than writes; the window covers both
    repeat (4) begin
      if (tgt_claim === 1'b1)
        seen_claim = 1'b1;
      if (tgt_done === 1'b1 && !seen_done) begin
        seen_done = 1'b1;
        seen_ack = tgt_ack64_n;
        seen_rdata = tgt_rdata;
      end
      @(negedge clk);
    end
  endtask

  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (frame_oe_n !== lvl && k < 4000) begin
      @(negedge clk);
      k++;
    end
    check({31'h0, frame_oe_n}, {31'h0, lvl});
  endtask

  task automatic dma_run(input logic tso, input logic [15:0] len,
                         input logic [31:0] a);
    logic [15:0] rem;
    logic [15:0] exp;
    int          k;
    rem = len;
    k = 0;
    while (dma_req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    check({31'h0, dma_req_ready}, 32'h1);
    dma_req_valid = 1'b1;
    dma_req_tso = tso;
    dma_req_addr = a;
    dma_req_len = len;
    @(negedge clk);
    dma_req_valid = 1'b0;
    while (rem != 16'h0000) begin
      exp = rem;
      if ((tso || pcix_now) && rem > 16'h2000)
        exp = 16'h2000;
      wait_oe(1'b0);
      check({30'h0, frame_n_out, bus_req_n}, 32'h1);
      if (tso || pcix_now)
        check({16'h0, mst_len}, {16'h0, exp});
      else
        check({16'h0, mst_len}, {16'h0, exp});
      check(mst_addr, a);
      wait_oe(1'b1);
      rem = rem - exp;
      a = a + {16'h0, exp};
    end
    repeat (4) @(negedge clk);
    check({31'h0, dma_busy}, 32'h0);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic reg_wide;
    tgt_op(1'b1, 1'b1, 1'b1, 32'h10, 64'h1111_0001_2222_0002, 8'h00);
    check({31'h0, seen_ack}, 32'h0);
    tgt_op(1'b1, 1'b1, 1'b1, 32'h14, 64'h3333_0003_4444_0004, 8'h00);
    check({31'h0, seen_ack}, 32'h0);
    tgt_op(1'b1, 1'b0, 1'b1, 32'h10, 64'h0, 8'h00);
    check(seen_rdata[63:32], 32'h3333_0003);
    check(seen_rdata[31:0], 32'h2222_0002);
    tgt_op(1'b1, 1'b1, 1'b0, 32'h10, 64'h5555_0005_6666_0006, 8'h00);
    tgt_op(1'b1, 1'b0, 1'b1, 32'h10, 64'h0, 8'h00);
    check(seen_rdata[63:32], 32'h3333_0003);
    check(seen_rdata[31:0], 32'h6666_0006);
  endtask

  task automatic reg_narrow;
    tgt_op(1'b1, 1'b1, 1'b0, 32'h24, 64'hdead_0000_abcd_0009, 8'h00);
    tgt_op(1'b1, 1'b1, 1'b1, 32'h20, 64'h7777_0007_8888_0008, 8'h00);
    check({31'h0, seen_ack}, 32'h1);
    tgt_op(1'b1, 1'b0, 1'b0, 32'h20, 64'h0, 8'h00);
    check(seen_rdata[31:0], 32'h8888_0008);
    check(seen_rdata[63:32], 32'habcd_0009);
    tgt_op(1'b1, 1'b0, 1'b0, 32'h24, 64'h0, 8'h00);
    check(seen_rdata[31:0], 32'habcd_0009);
  endtask

  task automatic flash_paths;
    int we0;
    int cs0;
    flash_size = 2'h3;
    @(negedge clk);
    rom_bar_we = 1'b1;
    rom_bar_wdata = 32'h0080_0001;
    @(negedge clk);
    rom_bar_we = 1'b0;
    check(rom_bar_rdata & 32'hfff8_0000, 32'h0080_0000);
    we0 = n_we;
    tgt_op(1'b0, 1'b1, 1'b1, 32'h0087_0000, 64'h9999_1234_5678, 8'h00);
    check({31'h0, seen_ack}, 32'h1);
    check(last_wdata, 32'h1234_5678);
    check({13'h0, flash_addr}, 32'h0007_0000);
    we0 = n_we;
    cs0 = n_cs;
    tgt_op(1'b0, 1'b1, 1'b0, 32'h0087_0004, 64'h0, 8'hff);
    check(n_we, we0);
    check(n_cs, cs0);
    tgt_op(1'b0, 1'b0, 1'b0, 32'h0080_0040, 64'h0, 8'h00);
    check(seen_rdata[31:0], flash_rdata);
    flash_size = 2'h0;
    tgt_op(1'b0, 1'b0, 1'b0, 32'h0081_0000, 64'h0, 8'h00);
    check({31'h0, seen_claim}, 32'h0);
    // Image breaks the keep-cleared convention on purpose
    @(negedge clk);
    eeprom_word_valid = 1'b1;
    eeprom_word_addr = 8'h0f;
    eeprom_word_data = 16'h0100;
    @(negedge clk);
    eeprom_word_valid = 1'b0;
    @(negedge clk);
    check(rom_bar_rdata, 32'h0000_0000);
    tgt_op(1'b0, 1'b0, 1'b0, 32'h0080_0000, 64'h0, 8'h00);
    check({31'h0, seen_claim | seen_done}, 32'h0);
    // Base at zero with decode on: disabled flash must still stay quiet
    @(negedge clk);
    rom_bar_we = 1'b1;
    rom_bar_wdata = 32'h0000_0001;
    @(negedge clk);
    rom_bar_we = 1'b0;
    tgt_op(1'b0, 1'b0, 1'b0, 32'h0000_0000, 64'h0, 8'h00);
    check({31'h0, seen_claim | seen_done}, 32'h0);
  endtask

  // ****
  // Monitors and main sequence
  // ****
  always @(negedge clk) begin
    if (flash_we_n === 1'b0) begin
      n_we++;
      last_wdata = flash_wdata;
    end
    if (flash_cs_n === 1'b0)
      n_cs++;
    if (frame_oe_n === 1'b0 && oe_was === 1'b1) begin
      if (pcix_now)
        check(gcnt <= pcix_host_bus_pkg::GNT_FRAME_PCIX_CLK, 1);
      else
        check(gcnt <= pcix_host_bus_pkg::GNT_FRAME_PCI_CLK, 1);
    end
    if (gnt_n_pin === 1'b0 && frame_oe_n === 1'b1)
      gcnt++;
    else
      gcnt = 0;
    oe_was = frame_oe_n;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #(60000 * 20);
    mismatches++;
    end_sim();
  end

  initial begin
    {sys_rst, strap_pcix, strap_wide, pcix_now, oe_was} = 5'h19;
    grant_delay = 4'h0;
    {eeprom_word_valid, rom_bar_we, tgt_valid, tgt_reg_sel} = 4'h0;
    {tgt_write, tgt_req64, dma_req_valid, dma_req_tso} = 4'h0;
    eeprom_word_addr = 8'h00;
    eeprom_word_data = 16'h0000;
    flash_size = 2'h0;
    rom_bar_wdata = 32'h0;
    tgt_addr = 32'h0;
    tgt_wdata = 64'h0;
    tgt_be_n = 8'hff;
    flash_rdata = 32'hc3a5_5a3c;
    dma_req_addr = 32'h0;
    dma_req_len = 16'h0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    do_reset(1'b1, 1'b1);
    reg_wide();
    dma_run(1'b1, 16'h3000, 32'h1000_0000);
    grant_delay = 4'h5;
    dma_run(1'b0, 16'h2000, 32'h2000_0000);
    flash_paths();
    do_reset(1'b0, 1'b1);
    reg_wide();
    dma_run(1'b0, 16'h3000, 32'h3000_0000);
    strap_pcix = 1'b1;
    dma_run(1'b0, 16'h3000, 32'h4000_0000);
    dma_run(1'b1, 16'h3000, 32'h5000_0000);
    do_reset(1'b1, 1'b0);
    reg_narrow();
    end_sim();
  end
endmodule
